// ### logic/fes_bus_cycle.sv
/*
 one asynchronous flash bus cycle: write with chip select and write strobe,
 or read with chip select and output strobe; every new read raises fresh
 strobes so the part refreshes its status. assumes pins synchronous to sys_clk.
*/
`timescale 1ns/10ps
module fes_bus_cycle
  import fes_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // request side
  input wire logic start,
  input wire fes_req_type req,
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  // flash pins
  output logic [ADDR_W-1:0] fl_addr,
  output logic [DATA_W-1:0] fl_dq_out,
  output logic fl_dq_oe_n,
  input wire logic [DATA_W-1:0] fl_dq_in,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);

  typedef enum logic [1:0] {
    BC_IDLE = 2'b00,
    BC_STROBE = 2'b01,
    BC_GAP = 2'b10
  } fes_bc_state_type;

  fes_bc_state_type state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic write_reg;

  wire cnt_zero = (cnt_reg == 4'h0);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_zero ? 4'h0 : cnt_reg - 4'h1;
    unique case (state_reg)
      BC_IDLE: begin
        if (start) begin
          state_next = BC_STROBE;
          cnt_next = STROBE_CNT - 4'h1;
        end
      end
      BC_STROBE: begin
        if (cnt_zero) begin
          state_next = BC_GAP;
          cnt_next = GAP_CNT - 4'h1;
        end
      end
      BC_GAP: begin
        if (cnt_zero) state_next = BC_IDLE;
      end
      default: state_next = BC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= BC_IDLE;
      cnt_reg <= 4'h0;
      write_reg <= 1'b0;
      fl_addr <= '0;
      fl_dq_out <= '0;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
      rdata <= '0;
      done <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done <= 1'b0;
      if (state_reg == BC_IDLE && start) begin
        write_reg <= req.write;
        fl_addr <= req.addr;
        fl_dq_out <= req.data;
        fl_dq_oe_n <= !req.write;
        fl_ce_n <= 1'b0;
        fl_we_n <= !req.write;
        fl_oe_n <= req.write;
      end else if (state_reg == BC_STROBE && cnt_zero) begin
        // command latched on strobe rise, status sampled before it
        if (!write_reg) rdata <= fl_dq_in; // R5
        fl_ce_n <= 1'b1;
        fl_we_n <= 1'b1;
        fl_oe_n <= 1'b1;
      end else if (state_reg == BC_GAP && cnt_zero) begin
        fl_dq_oe_n <= 1'b1;
        done <= 1'b1;
      end
    end
  end

  assign busy = (state_reg != BC_IDLE);

endmodule

// ### logic/fes_host.sv
/*
 host controller for block erase, erase suspend/resume and status checks of an
 asynchronous flash part. software orders operations through a small register
 port; results land in sticky interrupt status bits. assumes one 100 MHz clock.
*/
// Implementation choices: the address map and the address-and-strobe port.
// Functional notes
// R1 - a block erase is the setup code 20h then the confirm code D0h at an address in the block.
// R2 - after confirm the part only answers status reads and suspend until it is ready.
// R3 - suspend is code B0h, after which only array read, status read and resume are sent.
// R4 - resume is code D0h, which ends the suspended state and continues the erase.
// R5 - status is polled with a fresh strobe per read until the ready flag is one.
// R6 - a supply-low flag must be cleared before any further program or erase is started.
// R7 - the program error flag is cleared only by clear status and does not block programs.
// R8 - error flags accumulate so one full check may cover a series of operations.
// R9 - the erase error flag survives later erases and is cleared only by clear status.
// R10 - after the last erase the host writes FFh to return the part to array reads.
// R11 - while suspended the host may write FFh and reads only outside the erased block; the code reads at any address written to REG_ADDR.
// R12 - array reads during suspend start only after ready and suspended both read one.
`timescale 1ns/10ps
module fes_host
  import fes_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control port
  input wire logic [3:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [31:0] cpu_rdata,
  output logic irq,
  // flash pins
  output logic [ADDR_W-1:0] fl_addr,
  output logic [DATA_W-1:0] fl_dq_out,
  output logic fl_dq_oe_n,
  input wire logic [DATA_W-1:0] fl_dq_in,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SETUP = 4'b0001,
    ST_CONFIRM = 4'b0010,
    ST_POLL = 4'b0011,
    ST_SUSP_CMD = 4'b0100,
    ST_SUSP_POLL = 4'b0101,
    ST_SUSPENDED = 4'b0110,
    ST_RESUME = 4'b0111,
    ST_ARRAY_CMD = 4'b1000,
    ST_ARRAY_READ = 4'b1001,
    ST_CLEAR = 4'b1010,
    ST_STATUS_CMD = 4'b1011,
    ST_FINAL = 4'b1100
  } fes_state_type;

  fes_state_type state_reg, state_next;
  logic [ADDR_W-1:0] erase_addr_reg, read_addr_reg;
  logic [7:0] status_reg, array_data_reg;
  logic [IRQ_W-1:0] irq_status_reg, irq_enable_reg;
  logic issued_reg, suspend_req_reg, array_mode_reg, vpp_block_reg, suspend_active_reg;
  logic bc_start, bc_busy, bc_done;
  logic [DATA_W-1:0] bc_rdata;
  fes_req_type bc_req;

  function automatic fes_req_type wr_cmd(input logic [ADDR_W-1:0] a, input logic [7:0] c);
    wr_cmd.write = 1'b1;
    wr_cmd.addr = a;
    wr_cmd.data = c;
  endfunction

  // control port decode
  wire wr_ctrl = cpu_wr && (cpu_addr == REG_CTRL);
  wire go_erase = wr_ctrl && cpu_wdata[CTRL_ERASE];
  wire go_suspend = wr_ctrl && cpu_wdata[CTRL_SUSPEND];
  wire go_resume = wr_ctrl && cpu_wdata[CTRL_RESUME];
  wire go_clear = wr_ctrl && cpu_wdata[CTRL_CLEAR];
  wire go_array = wr_ctrl && cpu_wdata[CTRL_ARRAY];
  wire go_read = wr_ctrl && cpu_wdata[CTRL_READ];
  wire idle = (state_reg == ST_IDLE);
  wire suspended = (state_reg == ST_SUSPENDED);
  wire array_ok = suspended || (idle && array_mode_reg);
  wire poll_st = (state_reg == ST_POLL) || (state_reg == ST_SUSP_POLL);
  wire st_ready = bc_rdata[SB_READY];
  wire st_susp = bc_rdata[SB_SUSP];
  wire poll_done = bc_done && poll_st;
  wire erase_end = poll_done && st_ready && !st_susp;
  wire susp_reached = poll_done && st_ready && st_susp; // R12
  wire [IRQ_W-1:0] irq_set = {susp_reached,
                              erase_end && bc_rdata[SB_VPP_LOW],
                              erase_end && bc_rdata[SB_ERASE_ERR],
                              erase_end};
  wire [IRQ_W-1:0] irq_clr = (cpu_wr && cpu_addr == REG_IRQ_CLEAR) ?
                             cpu_wdata[IRQ_W-1:0] : '0;

  // next flash request
  always_comb begin
    bc_start = 1'b0;
    bc_req = wr_cmd(erase_addr_reg, CMD_READ_STATUS);
    unique case (state_reg)
      ST_SETUP: bc_req = wr_cmd(erase_addr_reg, CMD_ERASE_SETUP); // R1
      ST_CONFIRM: bc_req = wr_cmd(erase_addr_reg, CMD_CONFIRM); // R1
      ST_SUSP_CMD: bc_req = wr_cmd(erase_addr_reg, CMD_SUSPEND); // R3
      ST_RESUME: bc_req = wr_cmd(erase_addr_reg, CMD_CONFIRM); // R4
      ST_CLEAR: bc_req = wr_cmd(erase_addr_reg, CMD_CLEAR_STATUS); // R7 R9
      ST_STATUS_CMD: bc_req = wr_cmd(erase_addr_reg, CMD_READ_STATUS);
      ST_ARRAY_CMD, ST_FINAL: bc_req = wr_cmd(erase_addr_reg, CMD_READ_ARRAY); // R10 R11
      ST_POLL, ST_SUSP_POLL: begin
        bc_req.write = 1'b0;
        bc_req.data = '0;
      end
      ST_ARRAY_READ: begin
        bc_req.write = 1'b0;
        bc_req.addr = read_addr_reg; // R11
        bc_req.data = '0;
      end
      default: ;
    endcase
    if (!idle && !suspended && !bc_busy && !issued_reg) bc_start = 1'b1;
  end

  // sequence
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (go_erase && !vpp_block_reg) state_next = ST_SETUP; // R6
        else if (go_clear) state_next = ST_CLEAR;
        else if (go_array) state_next = ST_ARRAY_CMD;
        else if (go_read && array_mode_reg) state_next = ST_ARRAY_READ;
      end
      ST_SETUP: if (bc_done) state_next = ST_CONFIRM;
      // while busy only status polls and suspend go out
      ST_CONFIRM: if (bc_done) state_next = ST_POLL; // R2
      ST_POLL: begin
        if (bc_done && suspend_req_reg) state_next = ST_SUSP_CMD; // R2
        else if (erase_end) state_next = ST_FINAL; // R5 R10
      end
      ST_SUSP_CMD: if (bc_done) state_next = ST_SUSP_POLL;
      ST_SUSP_POLL: begin
        if (susp_reached) state_next = ST_SUSPENDED; // R12
        else if (erase_end) state_next = ST_FINAL;
      end
      ST_SUSPENDED: begin
        if (go_resume) state_next = ST_RESUME; // R3
        else if (go_array) state_next = ST_ARRAY_CMD; // R11
        else if (go_read && array_mode_reg) state_next = ST_ARRAY_READ;
        else if (go_clear) state_next = ST_STATUS_CMD;
      end
      ST_RESUME: if (bc_done) state_next = ST_POLL; // R4
      ST_ARRAY_CMD, ST_ARRAY_READ, ST_STATUS_CMD: begin
        if (bc_done) state_next = suspend_active_reg ? ST_SUSPENDED : ST_IDLE;
      end
      ST_CLEAR, ST_FINAL: if (bc_done) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      issued_reg <= 1'b0;
      suspend_req_reg <= 1'b0;
      suspend_active_reg <= 1'b0;
      array_mode_reg <= 1'b1;
      vpp_block_reg <= 1'b0;
      erase_addr_reg <= '0;
      read_addr_reg <= '0;
      status_reg <= 8'h00;
      array_data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      issued_reg <= (bc_start || issued_reg) && !bc_done && (state_next == state_reg);
      // only while erase polls, so no stale request re-suspends after resume
      if (go_suspend && state_reg == ST_POLL) suspend_req_reg <= 1'b1; // R3
      else if (state_reg == ST_SUSP_CMD) suspend_req_reg <= 1'b0;
      if (susp_reached) suspend_active_reg <= 1'b1;
      else if (state_reg == ST_RESUME) suspend_active_reg <= 1'b0; // R4
      if (state_reg == ST_SETUP || state_reg == ST_CLEAR) array_mode_reg <= 1'b0;
      else if (bc_done && (state_reg == ST_FINAL || state_reg == ST_ARRAY_CMD))
        array_mode_reg <= 1'b1;
      else if (bc_done && (state_reg == ST_RESUME || state_reg == ST_STATUS_CMD))
        array_mode_reg <= 1'b0;
      if (erase_end && bc_rdata[SB_VPP_LOW]) vpp_block_reg <= 1'b1; // R6
      else if (state_reg == ST_CLEAR && bc_done) vpp_block_reg <= 1'b0;
      if (poll_done) status_reg <= bc_rdata; // R8 R9
      if (bc_done && state_reg == ST_ARRAY_READ) array_data_reg <= bc_rdata;
      if (cpu_wr && cpu_addr == REG_ADDR && idle) erase_addr_reg <= cpu_wdata[ADDR_W-1:0];
      if (cpu_wr && cpu_addr == REG_ADDR) read_addr_reg <= cpu_wdata[ADDR_W-1:0];
    end
  end

  // interrupts and read port
  wire [31:0] rd_mux =
    (cpu_addr == REG_ADDR) ? {{(32-ADDR_W){1'b0}}, erase_addr_reg} :
    (cpu_addr == REG_STATE) ? {16'h0000, 3'b000, vpp_block_reg, array_mode_reg,
                               suspend_active_reg, 2'b00, status_reg} :
    (cpu_addr == REG_IRQ_STATUS) ? {28'h000_0000, irq_status_reg} :
    (cpu_addr == REG_IRQ_ENABLE) ? {28'h000_0000, irq_enable_reg} :
    (cpu_addr == REG_RDATA) ? {24'h00_0000, array_data_reg} : RESET_WORD;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= '0;
      irq_enable_reg <= '0;
      irq <= 1'b0;
      cpu_rdata <= RESET_WORD;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      if (cpu_wr && cpu_addr == REG_IRQ_ENABLE) irq_enable_reg <= cpu_wdata[IRQ_W-1:0];
      irq <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_enable_reg);
      cpu_rdata <= cpu_rd ? rd_mux : RESET_WORD;
    end
  end

  fes_bus_cycle u_cycle (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(bc_start),
    .req(bc_req),
    .busy(bc_busy),
    .done(bc_done),
    .rdata(bc_rdata),
    .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe_n(fl_dq_oe_n),
    .fl_dq_in(fl_dq_in),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );

endmodule

// ### logic/fes_pkg.sv
/*
 package for the flash erase/status host controller: command codes, status bit
 positions, register offsets of the control port, bus timing counts and carriers.
 assumes a 100 MHz system clock and a flash part on an 8-bit asynchronous bus.
*/
package fes_pkg;

  // clock and bus timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 80;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_NS = 30;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  localparam logic [3:0] GAP_CNT = 4'(GAP_CYC);

  // flash widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  // flash command codes
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

  // flash status bits
  localparam int SB_READY = 7;
  localparam int SB_SUSP = 6;
  localparam int SB_ERASE_ERR = 5;
  localparam int SB_PROG_ERR = 4;
  localparam int SB_VPP_LOW = 3;

  // control port register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_STATE = 4'h2;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h3;
  localparam logic [3:0] REG_IRQ_CLEAR = 4'h4;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] REG_RDATA = 4'h6;

  // control register bits (write 1 to start)
  localparam int CTRL_ERASE = 0;
  localparam int CTRL_SUSPEND = 1;
  localparam int CTRL_RESUME = 2;
  localparam int CTRL_CLEAR = 3;
  localparam int CTRL_ARRAY = 4;
  localparam int CTRL_READ = 5;

  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERASE_ERR = 1;
  localparam int IRQ_VPP_LOW = 2;
  localparam int IRQ_SUSPENDED = 3;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // one flash bus cycle request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fes_req_type;

  // control port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } fes_cpu_type;

endpackage

// ### sim/fes_flash_model.sv
/*
 behavioural flash part: erase, suspend, resume and sticky status.
 assumes strobes from fes_host; the bench sets erase length and faults.
*/
`timescale 1ns/10ps
module fes_flash_model
  import fes_pkg::*;
(
  // host pins
  input wire logic [ADDR_W-1:0] fl_addr,
  input wire logic [DATA_W-1:0] fl_dq_out,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic fl_ce_n,
  output logic [DATA_W-1:0] fl_dq_in,
  // faults and erase length
  input wire logic erase_fail,
  input wire logic supply_low,
  input wire logic [7:0] erase_polls
);
  logic [7:0] log_q[$];
  logic [7:0] left, last;
  logic [ADDR_W-1:0] conf_addr;
  logic setup, susp, eerr, vlow, arr;
  wire ready = (left == 8'h00) || susp;
  wire [7:0] stat = {ready, susp, eerr, 1'b0, vlow, 3'b000};
  wire [7:0] rd_val = arr ? (fl_addr[7:0] ^ 8'h5a) : stat;
  initial begin
    {left, setup, susp, eerr, vlow, arr, last, conf_addr} = '0;
  end
  // released bus shows the inverse of the last value
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? rd_val : ~last;
  always @(negedge fl_oe_n) begin
    if (!arr && !susp && left != 8'h00) left = left - 8'h01;
  end
  always @(posedge fl_oe_n) last = rd_val;
  always @(posedge fl_we_n) begin
    log_q.push_back(fl_dq_out);
    if (!ready) begin
      if (fl_dq_out == CMD_SUSPEND) susp = 1'b1;
    end else if (susp) begin
      if (fl_dq_out == CMD_READ_ARRAY) arr = 1'b1;
      if (fl_dq_out == CMD_READ_STATUS) arr = 1'b0;
      if (fl_dq_out == CMD_CONFIRM) {susp, arr} = 2'b00;
    end else if (setup) begin
      setup = 1'b0;
      if (fl_dq_out == CMD_CONFIRM && (supply_low || vlow)) vlow = 1'b1;
      else if (fl_dq_out == CMD_CONFIRM) begin
        conf_addr = fl_addr;
        left = erase_polls;
        eerr = eerr | erase_fail;
      end
    end else begin
      if (fl_dq_out == CMD_ERASE_SETUP) {setup, arr} = 2'b10;
      if (fl_dq_out == CMD_READ_ARRAY) arr = 1'b1;
      if (fl_dq_out == CMD_READ_STATUS) arr = 1'b0;
      if (fl_dq_out == CMD_CLEAR_STATUS) {eerr, vlow} = 2'b00;
    end
  end
endmodule

// ### sim/fes_host_chk.sv
/*
 flash pin timing checker for fes_host.
 assumes one clock domain; bound to every fes_host instance.
*/
`timescale 1ns/10ps
module fes_host_chk
  import fes_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control port
  input wire logic cpu_rd,
  input wire logic [31:0] cpu_rdata,
  // flash pins
  input wire logic [ADDR_W-1:0] fl_addr,
  input wire logic [DATA_W-1:0] fl_dq_out,
  input wire logic fl_dq_oe_n,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_write_pulse;
    (!fl_we_n && !fl_ce_n)[*8] ##1 fl_we_n;
  endsequence
  sequence s_read_pulse;
    (!fl_oe_n && !fl_ce_n)[*8] ##1 fl_oe_n;
  endsequence
  sequence s_gap;
    (fl_ce_n && fl_we_n && fl_oe_n)[*3];
  endsequence
  AST_WRITE_LEN: assert property ($fell(fl_we_n) |-> s_write_pulse)
    else $error("write strobe not eight cycles");
  AST_READ_LEN: assert property ($fell(fl_oe_n) |-> s_read_pulse)
    else $error("read strobe not eight cycles");
  AST_FRESH_GAP: assert property ($rose(fl_ce_n) |-> s_gap)
    else $error("strobes not released between cycles");
  AST_DRIVE_WRITE: assert property (!fl_we_n |-> !fl_dq_oe_n)
    else $error("data not driven during write");
  AST_FREE_READ: assert property (!fl_oe_n |-> fl_dq_oe_n && fl_we_n)
    else $error("data driven during read");
  AST_HOLD: assert property (!fl_ce_n && !$past(fl_ce_n)
    |-> $stable(fl_addr) && $stable(fl_dq_out))
    else $error("address or data moved in a cycle");
  AST_CONFIRM: assert property ($rose(fl_we_n) && fl_dq_out == CMD_ERASE_SETUP
    |-> ##[1:20] ($fell(fl_we_n) && fl_dq_out == CMD_CONFIRM))
    else $error("setup not followed by confirm");
  AST_RDATA_IDLE: assert property (!$past(cpu_rd) |-> cpu_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule

bind fes_host fes_host_chk fes_host_chk_inst (.sys_clk(sys_clk), .reset_n(reset_n),
  .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
  .fl_dq_oe_n(fl_dq_oe_n), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));

// ### sim/tb.sv
/*
 self-checking bench of fes_host with the flash model on its pins.
 assumes the control port map of fes_pkg; expected bytes kept in a queue.
*/
`timescale 1ns/10ps
module tb
  import fes_pkg::*;
;
  logic sys_clk, reset_n, cpu_wr, cpu_rd, irq, erase_fail, supply_low;
  logic fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n;
  logic [3:0] cpu_addr;
  logic [31:0] cpu_wdata, cpu_rdata, rd_word;
  logic [ADDR_W-1:0] fl_addr, seed_reg, blk_addr;
  logic [DATA_W-1:0] fl_dq_out, fl_dq_in;
  logic [7:0] erase_polls;
  logic [7:0] exp_q[$];
  int num_errors, check_count;
  fes_host fes_host_inst (.sys_clk(sys_clk), .reset_n(reset_n), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
    .irq(irq), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe_n(fl_dq_oe_n),
    .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
  fes_flash_model fes_flash_model_inst (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_ce_n(fl_ce_n), .fl_dq_in(fl_dq_in),
    .erase_fail(erase_fail), .supply_low(supply_low), .erase_polls(erase_polls));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [19:0] lfsr(input logic [19:0] v);
    return {v[18:0], v[19] ^ v[16]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge sys_clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge sys_clk);
    cpu_rd <= 1'b0;
    #1 rd_word = cpu_rdata;
  endtask
  task automatic wait_bit(input int b);
    int n;
    for (n = 0; n < 2000; n++) begin
      rd(REG_IRQ_STATUS);
      if (rd_word[b] === 1'b1) break;
    end
    if (n == 2000) begin
      num_errors++;
      report_and_stop();
    end else begin
      repeat (30) @(posedge sys_clk);
    end
  endtask
  task automatic erase(input logic [19:0] a);
    fes_flash_model_inst.log_q.delete();
    wr(REG_ADDR, {12'h000, a});
    wr(REG_CTRL, 32'h0000_0001);
  endtask
  task automatic cmp_log();
    check(32'(fes_flash_model_inst.log_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) check({24'h0, fes_flash_model_inst.log_q[i]}, {24'h0, exp_q[i]});
  endtask
  initial begin
    {reset_n, cpu_wr, cpu_rd, cpu_addr, cpu_wdata, erase_fail, supply_low} = '0;
    erase_polls = 8'd3;
    seed_reg = 20'd49;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int a = 2; a < 16; a++) begin
      if (a != 4) rd(a[3:0]);
      // state register comes out of reset in array mode
      if (a != 4) check(rd_word, (a == 2) ? 32'h0000_0800 : 32'h0000_0000);
    end
    $display("test reset done");
    seed_reg = lfsr(seed_reg);
    blk_addr = seed_reg;
    wr(REG_IRQ_ENABLE, 32'h0000_0001);
    erase(blk_addr);
    wait_bit(IRQ_DONE);
    exp_q = '{CMD_ERASE_SETUP, CMD_CONFIRM, CMD_READ_ARRAY};
    cmp_log();
    check({12'h0, fes_flash_model_inst.conf_addr}, {12'h0, blk_addr});
    check({31'h0, irq}, 32'h1);
    wr(REG_IRQ_CLEAR, 32'h0000_000f);
    rd(REG_IRQ_STATUS);
    check(rd_word, 32'h0000_0000);
    check({31'h0, irq}, 32'h0);
    $display("test erase done");
    wr(REG_IRQ_ENABLE, 32'h0000_0000);
    erase_fail = 1'b1;
    erase(lfsr(blk_addr));
    wait_bit(IRQ_ERASE_ERR);
    check({31'h0, irq}, 32'h0);
    erase_fail = 1'b0;
    wr(REG_IRQ_CLEAR, 32'h0000_000f);
    erase(blk_addr);
    wait_bit(IRQ_DONE);
    rd(REG_STATE);
    check({31'h0, rd_word[SB_ERASE_ERR]}, 32'h1);
    $display("test erase error done");
    supply_low = 1'b1;
    erase(blk_addr);
    wait_bit(IRQ_VPP_LOW);
    supply_low = 1'b0;
    erase(blk_addr);
    repeat (60) @(posedge sys_clk);
    check(32'(fes_flash_model_inst.log_q.size()), 32'h0);
    wr(REG_CTRL, 32'h0000_0008);
    repeat (40) @(posedge sys_clk);
    wr(REG_IRQ_CLEAR, 32'h0000_000f);
    wr(REG_ADDR, {12'h000, blk_addr});
    wr(REG_CTRL, 32'h0000_0001);
    wait_bit(IRQ_DONE);
    exp_q = '{CMD_CLEAR_STATUS, CMD_ERASE_SETUP, CMD_CONFIRM, CMD_READ_ARRAY};
    cmp_log();
    $display("test supply low done");
    erase_polls = 8'd60;
    wr(REG_IRQ_CLEAR, 32'h0000_000f);
    wr(REG_IRQ_ENABLE, 32'h0000_0008);
    erase(blk_addr);
    repeat (50) @(posedge sys_clk);
    wr(REG_CTRL, 32'h0000_0002);
    wait_bit(IRQ_SUSPENDED);
    check({31'h0, irq}, 32'h1);
    rd(REG_STATE);
    check({29'h0, rd_word[10], rd_word[7:6]}, 32'h7);
    check({24'h0, fes_flash_model_inst.log_q[2]}, {24'h0, CMD_SUSPEND});
    wr(REG_CTRL, 32'h0000_0010);
    repeat (20) @(posedge sys_clk);
    wr(REG_ADDR, {12'h000, blk_addr ^ 20'h8_0000});
    wr(REG_CTRL, 32'h0000_0020);
    repeat (40) @(posedge sys_clk);
    rd(REG_RDATA);
    check(rd_word, {24'h0, blk_addr[7:0] ^ 8'h5a});
    wr(REG_CTRL, 32'h0000_0004);
    wait_bit(IRQ_DONE);
    check({31'h0, fes_flash_model_inst.susp}, 32'h0);
    wr(REG_ADDR, {12'h000, blk_addr ^ 20'h0_0f0f});
    wr(REG_CTRL, 32'h0000_0020);
    repeat (20) @(posedge sys_clk);
    rd(REG_RDATA);
    check(rd_word, {24'h0, blk_addr[7:0] ^ 8'h0f ^ 8'h5a});
    $display("test suspend done");
    report_and_stop();
  end
endmodule
